// ### stbyc_params.svh
/*
 * constants of the standby controller: register address, field positions,
 * reset value and timing counts.
 * assumes inclusion by bare name from the controller sources.
 */
`ifndef STBYC_PARAMS_SVH
`define STBYC_PARAMS_SVH

// ==========================================================================
// register map
`define STBYC_CTL_ADDR 20'h0_FFC0
`define STBYC_CTL_RESET 8'h30

// ==========================================================================
// field positions
`define STBYC_BIT_SUB_OSC_STOP 7
`define STBYC_BIT_CLK_SEL_HI 6
`define STBYC_BIT_CLK_SEL_LO 4
`define STBYC_BIT_MAIN_OSC_STOP 2
`define STBYC_BIT_STOP_REQ 1
`define STBYC_BIT_HALT_REQ 0
`define STBYC_CTL_WMASK 8'hF7

// ==========================================================================
// timing
`define STBYC_CONFLICT_CLKS 6
`define STBYC_DIV_W 3

`endif

// ### stbyc_pkg.sv
/*
 * types of the standby controller.
 * assumes stbyc_params.svh is compiled alongside.
 */
package stbyc_pkg;
    typedef enum logic [1:0] {
        STBYC_REQ_NORMAL,
        STBYC_REQ_HALT,
        STBYC_REQ_STOP,
        STBYC_REQ_IDLE
    } stbyc_req_t;

    typedef enum logic [2:0] {
        STBYC_RUN,
        STBYC_CONFLICT,
        STBYC_HALT,
        STBYC_STOP,
        STBYC_IDLE,
        STBYC_MACRO
    } stbyc_state_t;
endpackage : stbyc_pkg

// ### stbyc_clkdiv.sv
/*
 * cpu clock enable generator: divide-by 1/2/4/8 of the main clock, or a
 * pulse on every synchronised rising subsystem clock edge.
 * assumes sub_tick is already synchronous to CLK.
 */
`timescale 1ns/1ns
`default_nettype none
`include "stbyc_params.svh"

module stbyc_clkdiv (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [2:0] sel,
    input wire logic sub_tick,
    input wire logic gate,
    output var logic cpu_tick
);
    typedef struct packed {
        logic [`STBYC_DIV_W-1:0] cnt;
        logic tick;
    } stbyc_div_t;

    stbyc_div_t s_q;
    stbyc_div_t s_d;

    always_comb begin
        logic [`STBYC_DIV_W-1:0] lim;
        lim = '0;
        s_d = s_q;
        unique case (sel[1:0])
            2'b00: lim = 3'h0;
            2'b01: lim = 3'h1;
            2'b10: lim = 3'h3;
            2'b11: lim = 3'h7;
        endcase
        s_d.tick = 1'b0;
        if (gate) begin
            s_d.cnt = '0;
        end else if (sel[2]) begin
            s_d.tick = sub_tick;
        end else if (s_q.cnt >= lim) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cpu_tick = s_q.tick;
endmodule : stbyc_clkdiv
`default_nettype wire

// ### stbyc_sync3.sv
/*
 * three-stage synchroniser with agreement of stages two and three.
 * assumes an asynchronous level input.
 */
`timescale 1ns/1ns
`default_nettype none

module stbyc_sync3 (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic din,
    output var logic dout,
    output var logic rise
);
    typedef struct packed {
        logic [2:0] ff;
        logic val;
        logic rise;
    } stbyc_sync_t;

    stbyc_sync_t s_q;
    stbyc_sync_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.ff = {s_q.ff[1:0], din};
        s_d.rise = 1'b0;
        // first stage is read only by the second
        if (s_q.ff[1] == s_q.ff[2] && s_q.ff[2] != s_q.val) begin
            s_d.val = s_q.ff[2];
            s_d.rise = s_q.ff[2];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.val;
    assign rise = s_q.rise;
endmodule : stbyc_sync3
`default_nettype wire

// ### stbyc_ctrl.sv
/*
 * standby controller: guarded standby control register, mode sequencer,
 * oscillator and cpu clock controls.
 * assumes the cpu core presents decoded write strobes and one-cycle events
 * on CLK; the external nmi and subsystem clock come from pins.
 */
`timescale 1ns/1ns
`default_nettype none
`include "stbyc_params.svh"

module stbyc_ctrl (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic GUARD_WR,
    input wire logic [7:0] GUARD_OP3,
    input wire logic [7:0] GUARD_OP4,
    input wire logic [19:0] GUARD_PC,
    input wire logic OTHER_WR,
    input wire logic [19:0] OTHER_ADDR,
    input wire logic [7:0] OTHER_WDATA,
    input wire logic IRQ_PEND,
    input wire logic WDT_IRQ,
    input wire logic NMI_PIN,
    input wire logic MACRO_REQ,
    input wire logic MACRO_DONE,
    input wire logic SUB_CLK_PIN,
    output logic [7:0] STANDBY_CTL_REG,
    output logic OPERR_IRQ,
    output logic [19:0] OPERR_RET_PC,
    output logic CPU_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic MAIN_OSC_EN,
    output logic SUB_OSC_EN,
    output logic CPU_ON_SUB,
    output logic FETCH_RESUME,
    output logic [2:0] STBY_STATE
);
    // ======================================================================
    // state record
    typedef struct packed {
        logic [7:0] ctl;
        stbyc_pkg::stbyc_state_t st;
        logic [2:0] cnt;
        logic operr;
        logic [19:0] ret_pc;
        logic resume;
    } stbyc_regs_t;

    stbyc_regs_t s_q;
    stbyc_regs_t s_d;

    logic nmi_rise;
    logic sub_rise;
    logic cpu_tick;
    logic cpu_gate;
    logic wake;
    logic bytes_ok;

    function automatic logic is_compl(input logic [7:0] a, input logic [7:0] b);
        is_compl = (a == ~b);
    endfunction : is_compl

    function automatic stbyc_pkg::stbyc_state_t mode_of(input logic [1:0] r);
        unique case (r)
            2'b01: mode_of = stbyc_pkg::STBYC_HALT;
            2'b10: mode_of = stbyc_pkg::STBYC_STOP;
            2'b11: mode_of = stbyc_pkg::STBYC_IDLE;
            default: mode_of = stbyc_pkg::STBYC_RUN;
        endcase
    endfunction : mode_of

    // ======================================================================
    // pins
    stbyc_sync3 u_nmi_sync (
        .clk(CLK),
        .arst_n(ARST_N),
        .din(NMI_PIN),
        .dout(),
        .rise(nmi_rise)
    );

    stbyc_sync3 u_sub_sync (
        .clk(CLK),
        .arst_n(ARST_N),
        .din(SUB_CLK_PIN),
        .dout(),
        .rise(sub_rise)
    );

    // ======================================================================
    // sequencer
    // watchdog is deliberately absent from the wake term
    assign wake = IRQ_PEND || nmi_rise;
    assign bytes_ok = is_compl(GUARD_OP3, GUARD_OP4);

    always_comb begin
        s_d = s_q;
        s_d.operr = 1'b0;
        s_d.resume = 1'b0;
        unique case (s_q.st)
            stbyc_pkg::STBYC_RUN: begin
                if (GUARD_WR && bytes_ok) begin
                    s_d.ctl = GUARD_OP4 & `STBYC_CTL_WMASK;
                    if (GUARD_OP4[1:0] != 2'b00) begin
                        if (IRQ_PEND) begin
                            s_d.ctl[1:0] = 2'b00;
                            s_d.st = stbyc_pkg::STBYC_CONFLICT;
                            s_d.cnt = '0;
                        end else begin
                            s_d.st = mode_of(GUARD_OP4[1:0]);
                        end
                    end
                end else if (GUARD_WR) begin
                    s_d.operr = 1'b1;
                    s_d.ret_pc = GUARD_PC;
                end
                // OTHER_WR deliberately has no effect here
            end
            stbyc_pkg::STBYC_CONFLICT: begin
                s_d.cnt = s_q.cnt + 3'h1;
                if (s_q.cnt == 3'(`STBYC_CONFLICT_CLKS - 2)) begin
                    s_d.st = stbyc_pkg::STBYC_RUN;
                    s_d.resume = 1'b1;
                end
            end
            stbyc_pkg::STBYC_HALT: begin
                if (wake) begin
                    s_d.ctl[1:0] = 2'b00;
                    s_d.st = stbyc_pkg::STBYC_RUN;
                    s_d.resume = 1'b1;
                end else if (MACRO_REQ) begin
                    s_d.st = stbyc_pkg::STBYC_MACRO;
                end
            end
            stbyc_pkg::STBYC_MACRO: begin
                if (MACRO_DONE) begin
                    s_d.st = stbyc_pkg::STBYC_HALT;
                end
            end
            stbyc_pkg::STBYC_STOP, stbyc_pkg::STBYC_IDLE: begin
                if (wake) begin
                    s_d.ctl[1:0] = 2'b00;
                    s_d.st = stbyc_pkg::STBYC_RUN;
                    s_d.resume = 1'b1;
                end
            end
            default: begin
                s_d.st = stbyc_pkg::STBYC_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_q.ctl <= `STBYC_CTL_RESET;
            s_q.st <= stbyc_pkg::STBYC_RUN;
            s_q.cnt <= '0;
            s_q.operr <= 1'b0;
            s_q.ret_pc <= '0;
            s_q.resume <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // clock controls
    // cpu runs in normal mode, during the conflict wait and during macro service only
    assign cpu_gate = !(s_q.st == stbyc_pkg::STBYC_RUN || s_q.st == stbyc_pkg::STBYC_CONFLICT ||
                        s_q.st == stbyc_pkg::STBYC_MACRO);

    stbyc_clkdiv u_div (
        .clk(CLK),
        .arst_n(ARST_N),
        .sel(s_q.ctl[6:4]),
        .sub_tick(sub_rise),
        .gate(cpu_gate),
        .cpu_tick(cpu_tick)
    );

    assign STANDBY_CTL_REG = s_q.ctl;
    assign OPERR_IRQ = s_q.operr;
    assign OPERR_RET_PC = s_q.ret_pc;
    assign CPU_CLK_EN = cpu_tick;
    assign PERIPH_CLK_EN = !(s_q.st == stbyc_pkg::STBYC_STOP || s_q.st == stbyc_pkg::STBYC_IDLE);
    // main oscillator stops in stop mode, or when its stop bit is set while the cpu is on the subsystem clock
    assign MAIN_OSC_EN = (s_q.st != stbyc_pkg::STBYC_STOP) &&
                         !(s_q.ctl[6] && s_q.ctl[2]);
    assign SUB_OSC_EN = !s_q.ctl[7];
    assign CPU_ON_SUB = s_q.ctl[6];
    assign FETCH_RESUME = s_q.resume;
    assign STBY_STATE = s_q.st;

    // ======================================================================
    // checks
    AST_OPERR: assert property (@(posedge CLK) disable iff (!ARST_N)
        (s_q.st == stbyc_pkg::STBYC_RUN && GUARD_WR && !bytes_ok) |=> OPERR_IRQ && $stable(STANDBY_CTL_REG))
        else $error("operand error missing");
    AST_RETPC: assert property (@(posedge CLK) disable iff (!ARST_N)
        (s_q.st == stbyc_pkg::STBYC_RUN && GUARD_WR && !bytes_ok) |=> OPERR_RET_PC == $past(GUARD_PC))
        else $error("wrong return address");
    AST_GOODWR: assert property (@(posedge CLK) disable iff (!ARST_N)
        (s_q.st == stbyc_pkg::STBYC_RUN && GUARD_WR && bytes_ok && GUARD_OP4[1:0] == 2'b00)
        |=> STANDBY_CTL_REG == ($past(GUARD_OP4) & 8'hF7))
        else $error("guarded write lost");
    AST_OTHER: assert property (@(posedge CLK) disable iff (!ARST_N)
        (OTHER_WR && !GUARD_WR) |=> $stable(STANDBY_CTL_REG) && !OPERR_IRQ)
        else $error("plain write took effect");
    AST_WDT: assert property (@(posedge CLK) disable iff (!ARST_N)
        (s_q.st == stbyc_pkg::STBYC_STOP && WDT_IRQ && !IRQ_PEND && !nmi_rise) |=> s_q.st == stbyc_pkg::STBYC_STOP)
        else $error("watchdog woke standby");
    AST_CONFLICT: assert property (@(posedge CLK) disable iff (!ARST_N)
        (s_q.st == stbyc_pkg::STBYC_RUN && GUARD_WR && bytes_ok && GUARD_OP4[1:0] != 2'b00 && IRQ_PEND)
        |-> ##[1:6] FETCH_RESUME)
        else $error("conflict resume late");
    AST_RELEASE: assert property (@(posedge CLK) disable iff (!ARST_N)
        (s_q.st == stbyc_pkg::STBYC_HALT && wake) |=> STANDBY_CTL_REG[1:0] == 2'b00 && FETCH_RESUME)
        else $error("release did not clear request");
    AST_MAINOSC: assert property (@(posedge CLK) disable iff (!ARST_N)
        (!STANDBY_CTL_REG[6] && s_q.st != stbyc_pkg::STBYC_STOP) |-> MAIN_OSC_EN)
        else $error("main oscillator stopped");
    AST_HALTCPU: assert property (@(posedge CLK) disable iff (!ARST_N)
        (s_q.st == stbyc_pkg::STBYC_HALT) [*2] |-> !CPU_CLK_EN && PERIPH_CLK_EN)
        else $error("cpu clock runs in halt");
    AST_MACRO: assert property (@(posedge CLK) disable iff (!ARST_N)
        (s_q.st == stbyc_pkg::STBYC_MACRO && MACRO_DONE) |=> s_q.st == stbyc_pkg::STBYC_HALT)
        else $error("macro did not return to halt");

    AST_STOPCLK: assert property (@(posedge CLK) disable iff (!ARST_N)
        (s_q.st == stbyc_pkg::STBYC_STOP) |-> !MAIN_OSC_EN && !PERIPH_CLK_EN)
        else $error("clocks run in stop");
    AST_IDLECLK: assert property (@(posedge CLK) disable iff (!ARST_N)
        (s_q.st == stbyc_pkg::STBYC_IDLE && !STANDBY_CTL_REG[6]) |-> MAIN_OSC_EN && !PERIPH_CLK_EN)
        else $error("idle clocks wrong");
    AST_SUBOSC: assert property (@(posedge CLK) disable iff (!ARST_N)
        SUB_OSC_EN == !STANDBY_CTL_REG[7])
        else $error("subsystem oscillator control wrong");
    AST_DROP: assert property (@(posedge CLK) disable iff (!ARST_N)
        (s_q.st == stbyc_pkg::STBYC_HALT && GUARD_WR && !wake) |=> $stable(STANDBY_CTL_REG))
        else $error("write in standby took effect");

    // ======================================================================
    // coverage
    COV_HALT: cover property (@(posedge CLK) s_q.st == stbyc_pkg::STBYC_HALT ##[1:20] FETCH_RESUME);
    COV_CONFLICT: cover property (@(posedge CLK) s_q.st == stbyc_pkg::STBYC_CONFLICT);
    COV_STOP: cover property (@(posedge CLK) s_q.st == stbyc_pkg::STBYC_STOP);
    COV_MACRO: cover property (@(posedge CLK) s_q.st == stbyc_pkg::STBYC_MACRO);
    COV_OPERR: cover property (@(posedge CLK) OPERR_IRQ);
endmodule : stbyc_ctrl
`default_nettype wire

// ### stbyc_cpu_model.sv
/*
 * cpu core model: issues guarded and plain writes to the standby register
 * and macro service strobes, each held over exactly one rising edge.
 * assumes its tasks are called from one process of the bench.
 */
`timescale 1ns/1ns
`default_nettype none

module stbyc_cpu_model (
    input wire logic clk,
    output var logic guard_wr,
    output var logic [7:0] guard_op3,
    output var logic [7:0] guard_op4,
    output var logic [19:0] guard_pc,
    output var logic other_wr,
    output var logic [19:0] other_addr,
    output var logic [7:0] other_wdata,
    output var logic macro_req,
    output var logic macro_done
);
    int quiet = 0;

    initial begin
        {guard_wr, other_wr, macro_req, macro_done} = 4'h0;
        {guard_op3, guard_op4, guard_pc} = 36'h0_0000_0000;
        {other_addr, other_wdata} = 28'h000_0000;
    end

    // the model always runs from a crystal, so stop needs no external clock select first
    // three nop slots after each guarded write keep wake order predictable
    always @(posedge clk) begin
        quiet <= (quiet > 0) ? quiet - 1 : 0;
    end

    // ========================================
    // instruction strobes
    task automatic guarded_write(input logic [7:0] data, input logic good, input logic [19:0] pc);
        while (quiet != 0) @(negedge clk);
        @(negedge clk);
        guard_op4 = data;
        guard_op3 = good ? ~data : data;
        guard_pc = pc;
        guard_wr = 1'b1;
        @(negedge clk);
        guard_wr = 1'b0;
        // released bytes both flip, so a good pair stays complementary and only guard_wr marks it stale
        guard_op3 = ~guard_op3;
        guard_op4 = ~guard_op4;
        quiet = 3;
    endtask : guarded_write

    task automatic other_write(input logic [19:0] addr, input logic [7:0] data);
        @(negedge clk);
        other_addr = addr;
        other_wdata = data;
        other_wr = 1'b1;
        @(negedge clk);
        other_wr = 1'b0;
        other_wdata = ~other_wdata;
    endtask : other_write

    task automatic macro_pulse(input logic done);
        @(negedge clk);
        macro_req = ~done;
        macro_done = done;
        @(negedge clk);
        {macro_req, macro_done} = 2'h0;
    endtask : macro_pulse
endmodule : stbyc_cpu_model

`default_nettype wire

// ### stbyc_ctrl_tb.sv
/*
 * self-checking bench of the standby controller: one task per scenario,
 * the cpu core model on the instruction side, pins driven here.
 * assumes the controller's own assertions run alongside.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %0t got %0h want %0h", $time, g, e); end end

module stbyc_ctrl_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic irq_pend = 1'b0;
    logic wdt_irq = 1'b0;
    logic nmi_pin = 1'b0;
    logic sub_clk = 1'b0;
    logic guard_wr, other_wr, macro_req, macro_done;
    logic [7:0] guard_op3, guard_op4, other_wdata, ctl;
    logic [19:0] guard_pc, other_addr, ret_pc;
    logic operr, cpu_en, periph_en, main_en, sub_en, on_sub, resume;
    logic [2:0] state;
    int error_cnt = 0;
    int checks = 0;

    always #5 clk = ~clk;
    // crystal of 16 cycles a period, its edges on clk falling edges, clear of the rising ones
    always #80 sub_clk = ~sub_clk;

    stbyc_cpu_model stbyc_cpu_model_inst (.clk(clk), .guard_wr(guard_wr), .guard_op3(guard_op3),
        .guard_op4(guard_op4), .guard_pc(guard_pc), .other_wr(other_wr), .other_addr(other_addr),
        .other_wdata(other_wdata), .macro_req(macro_req), .macro_done(macro_done));

    stbyc_ctrl stbyc_ctrl_inst (.CLK(clk), .ARST_N(arst_n), .GUARD_WR(guard_wr), .GUARD_OP3(guard_op3),
        .GUARD_OP4(guard_op4), .GUARD_PC(guard_pc), .OTHER_WR(other_wr), .OTHER_ADDR(other_addr),
        .OTHER_WDATA(other_wdata), .IRQ_PEND(irq_pend), .WDT_IRQ(wdt_irq), .NMI_PIN(nmi_pin),
        .MACRO_REQ(macro_req), .MACRO_DONE(macro_done), .SUB_CLK_PIN(sub_clk), .STANDBY_CTL_REG(ctl),
        .OPERR_IRQ(operr), .OPERR_RET_PC(ret_pc), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(periph_en),
        .MAIN_OSC_EN(main_en), .SUB_OSC_EN(sub_en), .CPU_ON_SUB(on_sub), .FETCH_RESUME(resume),
        .STBY_STATE(state));

    // ========================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    task automatic wr(input logic [7:0] d);
        stbyc_cpu_model_inst.guarded_write(d, 1'b1, 20'h0_0100);
    endtask : wr

    task automatic ticks(input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(negedge clk);
            if (cpu_en === 1'b1) cnt++;
        end
    endtask : ticks

    task automatic wake(input int lim);
        for (int i = 0; i < lim && resume !== 1'b1; i++) @(negedge clk);
        `CHK(resume, 1'b1)
        irq_pend = 1'b0;
        nmi_pin = 1'b0;
    endtask : wake

    // ========================================
    // scenarios
    task automatic t_reset;
        `CHK(ctl, 8'h30)
        `CHK(sub_en, 1'b1)
        `CHK(main_en, 1'b1)
        `CHK(on_sub, 1'b0)
        $display("test reset done");
    endtask : t_reset

    task automatic t_halt;
        int n;
        wr(8'h31);
        `CHK(ctl, 8'h31)
        `CHK(state, stbyc_pkg::STBYC_HALT)
        step(1);
        wdt_irq = 1'b1;
        ticks(8, n);
        wdt_irq = 1'b0;
        `CHK(n, 0)
        `CHK(periph_en, 1'b1)
        `CHK(state, stbyc_pkg::STBYC_HALT)
        irq_pend = 1'b1;
        wake(3);
        `CHK(ctl, 8'h30)
        $display("test halt done");
    endtask : t_halt

    task automatic t_stop_idle;
        wr(8'h32);
        step(1);
        `CHK(state, stbyc_pkg::STBYC_STOP)
        `CHK(main_en, 1'b0)
        `CHK(periph_en, 1'b0)
        wdt_irq = 1'b1;
        step(4);
        wdt_irq = 1'b0;
        `CHK(state, stbyc_pkg::STBYC_STOP)
        nmi_pin = 1'b1;
        wake(8);
        `CHK(ctl, 8'h30)
        wr(8'h33);
        step(1);
        `CHK(state, stbyc_pkg::STBYC_IDLE)
        `CHK(main_en, 1'b1)
        `CHK(periph_en, 1'b0)
        irq_pend = 1'b1;
        wake(3);
        `CHK(ctl, 8'h30)
        $display("test stop and idle done");
    endtask : t_stop_idle

    task automatic t_operr;
        stbyc_cpu_model_inst.guarded_write(8'h31, 1'b0, 20'h1_2345);
        `CHK(operr, 1'b1)
        `CHK(ret_pc, 20'h1_2345)
        `CHK(ctl, 8'h30)
        stbyc_cpu_model_inst.other_write(20'h0_FFC0, 8'h31);
        `CHK(operr, 1'b0)
        `CHK(ctl, 8'h30)
        `CHK(ret_pc, 20'h1_2345)
        $display("test operand error done");
    endtask : t_operr

    task automatic t_clk;
        int n;
        for (int s = 0; s < 4; s++) begin
            wr({1'b0, 3'(s), 4'h0});
            step(2);
            ticks(32, n);
            `CHK(n, 32 >> s)
        end
        wr(8'h40);
        `CHK(on_sub, 1'b1)
        wr(8'h74);
        step(2);
        `CHK(main_en, 1'b0)
        ticks(64, n);
        `CHK(n, 4)
        wr(8'h04);
        step(1);
        `CHK(main_en, 1'b1)
        wr(8'h88);
        step(1);
        `CHK(ctl, 8'h80)
        `CHK(sub_en, 1'b0)
        wr(8'h30);
        $display("test clock select done");
    endtask : t_clk

    task automatic t_low_power;
        int n;
        wr(8'h71);
        step(1);
        `CHK(state, stbyc_pkg::STBYC_HALT)
        ticks(32, n);
        `CHK(n, 0)
        stbyc_cpu_model_inst.macro_pulse(1'b0);
        `CHK(state, stbyc_pkg::STBYC_MACRO)
        stbyc_cpu_model_inst.macro_pulse(1'b1);
        `CHK(state, stbyc_pkg::STBYC_HALT)
        irq_pend = 1'b1;
        wake(3);
        `CHK(ctl, 8'h70)
        wr(8'h73);
        step(1);
        `CHK(state, stbyc_pkg::STBYC_IDLE)
        `CHK(sub_en, 1'b1)
        irq_pend = 1'b1;
        wake(3);
        wr(8'h30);
        $display("test low power done");
    endtask : t_low_power

    task automatic t_conflict;
        irq_pend = 1'b1;
        wr(8'h31);
        `CHK(state, stbyc_pkg::STBYC_CONFLICT)
        `CHK(ctl[1:0], 2'b00)
        wake(5);
        $display("test conflict done");
    endtask : t_conflict

    task automatic results;
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_reset;
        t_halt;
        t_stop_idle;
        t_operr;
        t_clk;
        t_low_power;
        t_conflict;
        results;
    end

    // all scenarios need under 1000 cycles; five times that means a hang
    initial begin
        #50000;
        error_cnt++;
        results;
    end
endmodule : stbyc_ctrl_tb

`default_nettype wire
